/* rtl/vfc_cal.sv */
// Purpose: VCO band calibration control with its configuration registers
// Assumes: clk is the oscillator input; register port single cycle, read data one cycle later
// Notes: vco_high is the band comparator: high when the VCO runs above target
//
// Contract
// - mode codes 0 to 3 pick the automatic timebase by oscillator band, codes 5 to 7 are reserved.
// - in automatic modes the manual constant and timing adjust bit are ignored.
// - divider codes 1, 2, 3 give divide by 2, 4, 8 of the oscillator; code 0 is reserved.
// - the calibration divider runs independently of the reference counter and detector rate.
// - linear search walks the bands one at a time until the right band is found.
// - mixed search halves the range first, then finishes linearly.
`include "vfc_consts.svh"
module vfc_cal
	import vfc_pkg::*;
#(
	parameter int LIN_BITS = 2
)(
	input  wire logic                   clk,
	input  wire logic                   srst,
	input  wire logic [7:0]             addr,
	input  wire logic [31:0]            wdata,
	input  wire logic                   wr,
	input  wire logic                   rd,
	output logic      [31:0]            rdata,
	input  wire logic                   vco_high,
	output logic      [`VFC_BAND_W-1:0] vco_band,
	output logic                        cal_busy,
	output logic                        cal_done,
	output logic      [3:0]             vco_noise_opt_sel,
	output logic      [15:0]            freq_word
);
	// refuse a finish width that the bit index cannot serve
	if (LIN_BITS < 1 || LIN_BITS >= `VFC_BAND_W) begin : g_bad_lin
		$error("LIN_BITS must be between 1 and band width minus 1");
	end

	vfc_ctl_t  s;
	vfc_ctl_t  next_s;
	vfc_ref_if ref_if ();
	logic      start;
	logic      cfg_wr;
	logic      cmp;
	logic      want_up;
	logic      at_edge;
	logic [12:0] win_len;

	vfc_ref_div u_div (
		.clk    (clk),
		.srst   (srst),
		.ref_if (ref_if.div)
	);

	// a settings change realigns the timebase; a window already under way keeps its count across the new ratio
	assign ref_if.div_code = s.div_sel;
	assign ref_if.restart  = cfg_wr;
	assign cfg_wr = wr && (addr == `VFC_OFS_CFG);
	assign start  = wr && (addr == `VFC_OFS_FREQ);

	// window length: manual fields only count in manual mode
	always_comb begin
		case (s.mode_sel)
			3'h0:    win_len = `VFC_AUTO_WIN0;
			3'h1:    win_len = `VFC_AUTO_WIN1;
			3'h2:    win_len = `VFC_AUTO_WIN2;
			3'h3:    win_len = `VFC_AUTO_WIN3;
			3'h4:    win_len = s.timing_adj ? {s.man_const, 1'b0} : {1'b0, s.man_const};
			default: win_len = `VFC_AUTO_WIN3; // reserved codes fall back to the longest window
		endcase
		if (win_len == 13'h0000) begin
			win_len = 13'h0001; // a zero constant would stretch a window to 8192 ticks
		end
	end

	// one comparison at the end of each window of divided ticks
	assign cmp     = s.busy && ref_if.tick && (s.win_cnt + 13'h0001 == win_len);
	assign want_up = !vco_high;
	assign at_edge = want_up ? (s.band == '1) : (s.band == '0);

	always_comb begin
		next_s = s;
		next_s.rdata = 32'h0000_0000;
		// register writes
		if (cfg_wr) begin
			next_s.mode_sel   = wdata[`VFC_CFG_MODE_LSB +: 3];
			next_s.div_sel    = wdata[`VFC_CFG_DIV_LSB +: 2];
			next_s.search     = wdata[`VFC_CFG_SRCH_LSB +: 2];
			next_s.timing_adj = wdata[`VFC_CFG_ADJ_BIT];
			next_s.noise_opt  = wdata[`VFC_CFG_NOISE_LSB +: 4];
		end
		if (wr && addr == `VFC_OFS_MANUAL) begin
			next_s.man_const = wdata[11:0];
		end
		if (wr && addr == `VFC_OFS_STATUS && wdata[`VFC_ST_ERR_BIT]) begin
			next_s.err = 1'b0;
		end
		// a reserved code sets the error flag; the set wins over a clear
		if (cfg_wr && (wdata[`VFC_CFG_MODE_LSB +: 3] > `VFC_MODE_MANUAL
				|| wdata[`VFC_CFG_DIV_LSB +: 2] == 2'h0
				|| wdata[`VFC_CFG_SRCH_LSB +: 2] == 2'h0
				|| wdata[`VFC_CFG_SRCH_LSB +: 2] == 2'h3)) begin
			next_s.err = 1'b1;
		end
		// window counter
		if (s.busy && ref_if.tick) begin
			next_s.win_cnt = cmp ? 13'h0000 : s.win_cnt + 13'h0001;
		end
		// band search
		case (s.state)
			VFC_HALVE: begin
				if (cmp) begin
					if (vco_high) begin
						next_s.band[s.bit_idx] = 1'b0;
					end
					if (s.bit_idx == 3'(LIN_BITS)) begin
						next_s.state = VFC_STEP;
						next_s.first = 1'b1;
					end else begin
						next_s.bit_idx = s.bit_idx - 3'h1;
						next_s.band[s.bit_idx - 3'h1] = 1'b1;
					end
				end
			end
			VFC_STEP: begin
				if (cmp) begin
					next_s.first  = 1'b0;
					next_s.dir_up = want_up;
					// stop when the comparator turns round or the last band is reached
					if ((!s.first && want_up != s.dir_up) || at_edge) begin
						next_s.state = VFC_IDLE;
						next_s.busy  = 1'b0;
						next_s.done  = 1'b1;
					end else begin
						next_s.band = want_up ? s.band + 1'b1 : s.band - 1'b1;
					end
				end
			end
			default: begin
				next_s.state = VFC_IDLE;
			end
		endcase
		// a new frequency restarts the search at any point: mixed from the midpoint, linear from the current band
		if (start) begin
			next_s.freq_word = wdata[15:0];
			next_s.busy    = 1'b1;
			next_s.done    = 1'b0;
			next_s.win_cnt = 13'h0000;
			next_s.first   = 1'b1;
			if (s.search == `VFC_SRCH_MIXED) begin
				next_s.state   = VFC_HALVE;
				next_s.band    = `VFC_BAND_MID;
				next_s.bit_idx = 3'(`VFC_BAND_W - 1);
			end else begin
				next_s.state = VFC_STEP;
			end
		end
		// read data, valid the cycle after the strobe
		if (rd) begin
			case (addr)
				`VFC_OFS_CFG: begin
					next_s.rdata[`VFC_CFG_MODE_LSB +: 3]  = s.mode_sel;
					next_s.rdata[`VFC_CFG_DIV_LSB +: 2]   = s.div_sel;
					next_s.rdata[`VFC_CFG_SRCH_LSB +: 2]  = s.search;
					next_s.rdata[`VFC_CFG_ADJ_BIT]        = s.timing_adj;
					next_s.rdata[`VFC_CFG_NOISE_LSB +: 4] = s.noise_opt;
				end
				`VFC_OFS_MANUAL: next_s.rdata[11:0] = s.man_const;
				`VFC_OFS_FREQ:   next_s.rdata[15:0] = s.freq_word;
				`VFC_OFS_STATUS: begin
					next_s.rdata[`VFC_ST_BUSY_BIT] = s.busy;
					next_s.rdata[`VFC_ST_DONE_BIT] = s.done;
					next_s.rdata[`VFC_ST_ERR_BIT]  = s.err;
					next_s.rdata[`VFC_ST_BAND_LSB +: `VFC_BAND_W] = s.band;
				end
				default: next_s.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s <= '0;
			s.mode_sel  <= `VFC_RST_MODE;
			s.div_sel   <= `VFC_RST_DIV;
			s.search    <= `VFC_RST_SRCH;
			s.noise_opt <= `VFC_RST_NOISE;
			s.man_const <= `VFC_RST_MANUAL;
			s.band      <= `VFC_BAND_MID;
			s.state     <= VFC_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign rdata             = s.rdata;
	assign vco_band          = s.band;
	assign cal_busy          = s.busy;
	assign cal_done          = s.done;
	assign vco_noise_opt_sel = s.noise_opt;
	assign freq_word         = s.freq_word;

	sequence seq_mixed_start;
		start && s.search == `VFC_SRCH_MIXED;
	endsequence
	sequence seq_halving;
		s.state == VFC_HALVE && s.band == `VFC_BAND_MID;
	endsequence

	a_mixed_halves: assert property (@(posedge clk) disable iff (srst)
		seq_mixed_start |=> seq_halving)
		else $error("mixed search did not start at the midpoint");
	a_linear_step: assert property (@(posedge clk) disable iff (srst || start)
		(s.state == VFC_STEP && cmp && s.first && vco_high && s.band != '0)
		|=> s.band == $past(s.band) - 1'b1)
		else $error("linear search did not step down one band");
	a_auto_window: assert property (@(posedge clk) disable iff (srst)
		(s.mode_sel == 3'h0 && s.busy && ref_if.tick && s.win_cnt == 13'h000F) |-> cmp)
		else $error("automatic window ignored its fixed length");
	a_start_busy: assert property (@(posedge clk) disable iff (srst)
		start |=> s.busy && !s.done && s.freq_word == $past(wdata[15:0]))
		else $error("frequency write did not start calibration");
	a_reserved_err: assert property (@(posedge clk) disable iff (srst)
		(cfg_wr && wdata[2:0] > 3'h4) |=> s.err)
		else $error("reserved mode code not flagged");
endmodule // vfc_cal

/* rtl/vfc_consts.svh */
// Purpose: offsets, field positions, reset values and timing counts of the calibration block
// Assumes: included by bare name from the package, vfc_cal and the bench
// Notes: one 32-bit word per register; bits not listed read as zero
`ifndef VFC_CONSTS_SVH
`define VFC_CONSTS_SVH

// register byte offsets
`define VFC_OFS_CFG      8'h00
`define VFC_OFS_MANUAL   8'h04
`define VFC_OFS_FREQ     8'h08
`define VFC_OFS_STATUS   8'h0C

// configuration word field positions
`define VFC_CFG_MODE_LSB   0
`define VFC_CFG_DIV_LSB    4
`define VFC_CFG_SRCH_LSB   8
`define VFC_CFG_ADJ_BIT    12
`define VFC_CFG_NOISE_LSB  16

// status word field positions
`define VFC_ST_BUSY_BIT    0
`define VFC_ST_DONE_BIT    1
`define VFC_ST_ERR_BIT     2
`define VFC_ST_BAND_LSB    8

// reset values
`define VFC_RST_MODE       3'h0
`define VFC_RST_DIV        2'h1
`define VFC_RST_SRCH       2'h1
`define VFC_RST_NOISE      4'h8
`define VFC_RST_MANUAL     12'h000

// codes
`define VFC_MODE_MANUAL    3'h4
`define VFC_SRCH_LINEAR    2'h1
`define VFC_SRCH_MIXED     2'h2

// comparison window, in divided reference ticks, for the automatic modes
`define VFC_AUTO_WIN0      13'h0010
`define VFC_AUTO_WIN1      13'h0020
`define VFC_AUTO_WIN2      13'h0030
`define VFC_AUTO_WIN3      13'h0040

// band code width and search midpoint
`define VFC_BAND_W         6
`define VFC_BAND_MID       6'h20

`endif

/* rtl/vfc_pkg.sv */
// Purpose: types shared by the calibration block modules
// Assumes: constants come from vfc_consts.svh
// Notes: state of each module is one packed struct
`include "vfc_consts.svh"
package vfc_pkg;

	typedef enum logic [1:0] {
		VFC_IDLE  = 2'b00,
		VFC_HALVE = 2'b01,
		VFC_STEP  = 2'b10
	} vfc_state_t;

	typedef struct packed {
		logic [2:0]              mode_sel;
		logic [1:0]              div_sel;
		logic [1:0]              search;
		logic                    timing_adj;
		logic [3:0]              noise_opt;
		logic [11:0]             man_const;
		logic [15:0]             freq_word;
		logic [`VFC_BAND_W-1:0]  band;
		vfc_state_t              state;
		logic [2:0]              bit_idx;
		logic                    first;
		logic                    dir_up;
		logic [12:0]             win_cnt;
		logic                    busy;
		logic                    done;
		logic                    err;
		logic [31:0]             rdata;
	} vfc_ctl_t;

	typedef struct packed {
		logic [2:0] cnt;
		logic       tick;
	} vfc_div_t;

endpackage

/* rtl/vfc_ref_div.sv */
// Purpose: divides the oscillator clock down to the calibration timebase tick
// Assumes: clk is the oscillator input; srst synchronous active high
// Notes: free running; nothing but its own code and restart steers it
module vfc_ref_div
	import vfc_pkg::*;
(
	input  wire logic clk,
	input  wire logic srst,
	vfc_ref_if.div    ref_if
);
	vfc_div_t r;
	vfc_div_t next_r;
	logic [2:0] last;

	// terminal count per code; the reserved code runs as divide by 2
	always_comb begin
		case (ref_if.div_code)
			2'h2:    last = 3'h3;
			2'h3:    last = 3'h7;
			default: last = 3'h1;
		endcase
	end

	// count independent of any other divider in the synthesizer
	always_comb begin
		next_r = r;
		next_r.tick = (r.cnt == last);
		next_r.cnt = (r.cnt == last) ? 3'h0 : r.cnt + 3'h1;
		if (ref_if.restart) begin
			next_r.cnt = 3'h0;
			next_r.tick = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign ref_if.tick = r.tick;

	a_div_two: assert property (@(posedge clk) disable iff (srst || ref_if.restart)
		(r.tick && ref_if.div_code == 2'h1) |=> !r.tick ##1 r.tick)
		else $error("divide by 2 tick spacing wrong");
	a_div_four: assert property (@(posedge clk) disable iff (srst || ref_if.restart)
		(r.tick && ref_if.div_code == 2'h2) |=> (!r.tick)[*3] ##1 r.tick)
		else $error("divide by 4 tick spacing wrong");
	a_div_eight: assert property (@(posedge clk) disable iff (srst || ref_if.restart)
		(r.tick && ref_if.div_code == 2'h3) |=> (!r.tick)[*7] ##1 r.tick)
		else $error("divide by 8 tick spacing wrong");
endmodule // vfc_ref_div

/* rtl/vfc_ref_if.sv */
// Purpose: carries divider setting and divided reference tick between the block's modules
// Assumes: single clock domain
// Notes: restart realigns the divider after a setting change
interface vfc_ref_if;
	logic [1:0] div_code;
	logic       restart;
	logic       tick;

	modport div (input div_code, input restart, output tick);
	modport ctl (output div_code, output restart, input tick);
endinterface

/* verif/vfc_cal_bench.sv */
// Purpose: self-checking bench for the band calibration block
// Assumes: 25 MHz clock, synchronous active-high reset held 16 cycles
// Notes: linear search is taken to start from the band left by the last run
`include "vfc_consts.svh"
module vco_freq_calibration_config_bench
	import vfc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, srst = 1, wr = 0, rd = 0, vco_high = 0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rdata, q;
	logic [5:0]  vco_band, tgt = 6'h00;
	logic        cal_busy, cal_done;
	logic [3:0]  vco_noise_opt_sel;
	logic [15:0] freq_word;
	int          err_total = 0, total_checks = 0;

	// block under test with its default linear finish width
	vfc_cal vfc_cal_inst (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .vco_high(vco_high), .vco_band(vco_band),
		.cal_busy(cal_busy), .cal_done(cal_done), .vco_noise_opt_sel(vco_noise_opt_sel),
		.freq_word(freq_word));

	// 40 ns period
	initial begin
		forever #20 clk = ~clk;
	end

	// comparator stand-in: high while the band sits above the target
	always @(posedge clk) begin
		vco_high <= vco_band > tgt;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_rng(input string nm, input int lo, hi, input logic [31:0] g);
		total_checks++;
		if ($isunknown(g) || g < lo || g > hi) begin
			err_total++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask

	// strobe for one cycle; the gap cycle after it keeps drivers apart
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	function automatic logic [31:0] cfgw(input int m, dv, s, adj, nz);
		return 32'(m) | 32'(dv) << 4 | 32'(s) << 8 | 32'(adj) << 12 | 32'(nz) << 16;
	endfunction

	// bounded wait so a stuck search cannot hang the run
	task automatic wait_done(output int n);
		n = 1;
		while (cal_done !== 1'b1 && n < 2000) begin
			@(posedge clk);
			#1 n++;
		end
	endtask

	task automatic cal_run(input logic [31:0] cfg, input logic [5:0] t,
		input int blo, bhi, clo, chi);
		int n;
		tgt = t;
		wr_reg(`VFC_OFS_CFG, cfg);
		wr_reg(`VFC_OFS_MANUAL, 32'h0000_0008);
		wr_reg(`VFC_OFS_FREQ, 32'h0000_1234);
		chk("busy", 1, cal_busy);
		wait_done(n);
		chk_rng("cycles", clo, chi, n);
		chk_rng("band", blo, bhi, vco_band);
		rd_reg(`VFC_OFS_STATUS, q);
		chk("status flags", 32'h0000_0002, q & 32'hffff_c0ff);
		chk_rng("status band", blo, bhi, q[`VFC_ST_BAND_LSB +: 6]);
	endtask

	task automatic test_reset();
		rd_reg(`VFC_OFS_CFG, q);
		chk("cfg", 32'h0008_0110, q);
		rd_reg(`VFC_OFS_MANUAL, q);
		chk("manual", 32'h0000_0000, q);
		rd_reg(`VFC_OFS_STATUS, q);
		chk("status", 32'h0000_2000, q);
		rd_reg(8'h10, q);
		chk("unmapped", 32'h0000_0000, q);
		chk("noise", 4'h8, vco_noise_opt_sel);
		chk("freq", 16'h0000, freq_word);
		wr_reg(`VFC_OFS_CFG, cfgw(0, 1, 1, 0, 6));
		chk("noise", 4'h6, vco_noise_opt_sel);
		$display("test_reset done");
	endtask

	// reserved mode, divider and search codes flag an error that clears on write-1
	task automatic test_reserved();
		logic [31:0] c [6] = '{cfgw(5, 1, 1, 0, 8), cfgw(6, 1, 1, 0, 8),
			cfgw(7, 1, 1, 0, 8), cfgw(0, 0, 1, 0, 8), cfgw(0, 1, 0, 0, 8), cfgw(0, 1, 3, 0, 8)};
		foreach (c[i]) begin
			wr_reg(`VFC_OFS_CFG, c[i]);
			rd_reg(`VFC_OFS_STATUS, q);
			chk("err set", 1, q[`VFC_ST_ERR_BIT]);
			wr_reg(`VFC_OFS_CFG, cfgw(0, 1, 1, 0, 8));
			wr_reg(`VFC_OFS_STATUS, 32'h0000_0004);
			rd_reg(`VFC_OFS_STATUS, q);
			chk("err clear", 0, q[`VFC_ST_ERR_BIT]);
		end
		$display("test_reserved done");
	endtask

	// three compares per run; k is window ticks times clocks per tick
	task automatic test_timebase();
		int k [8] = '{32, 64, 128, 64, 96, 128, 16, 32};
		logic [31:0] c [8] = '{cfgw(0, 1, 1, 1, 8), cfgw(0, 2, 1, 0, 8),
			cfgw(0, 3, 1, 0, 8), cfgw(1, 1, 1, 0, 8), cfgw(2, 1, 1, 0, 8),
			cfgw(3, 1, 1, 0, 8), cfgw(4, 1, 1, 0, 8), cfgw(4, 1, 1, 1, 8)};
		foreach (c[i]) begin
			cal_run(c[i], 6'h1e - 6'(2 * i), 30 - 2 * i, 30 - 2 * i, 2 * k[i] + 1, 4 * k[i] + 8);
		end
		$display("test_timebase done");
	endtask

	// far target: halving must beat the 11 steps a linear walk from band 16 would need
	task automatic test_mixed();
		cal_run(cfgw(0, 1, 2, 0, 8), 6'h05, 4, 6, 97, 392);
		$display("test_mixed done");
	endtask

	// a second frequency write mid-run restarts and clears done
	task automatic test_restart();
		int n;
		// settings that suit the 25 MHz clock: auto mode, divide by 4, mixed allowed
		wr_reg(`VFC_OFS_CFG, cfgw(0, 2, 2, 0, 8));
		wr_reg(`VFC_OFS_MANUAL, 32'h0000_0032);
		wr_reg(`VFC_OFS_FREQ, 32'h0000_00aa);
		wr_reg(`VFC_OFS_FREQ, 32'h0000_0055);
		chk("freq", 16'h0055, freq_word);
		chk("done", 0, cal_done);
		chk("busy", 1, cal_busy);
		wait_done(n);
		chk("done", 1, cal_done);
		$display("test_restart done");
	endtask

	// reset in mid-run drops the search and brings the settings back
	task automatic test_midreset();
		wr_reg(`VFC_OFS_FREQ, 32'h0000_0077);
		repeat (40) @(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1;
		chk("busy", 0, cal_busy);
		chk("done", 0, cal_done);
		chk("band", `VFC_BAND_MID, vco_band);
		chk("freq", 16'h0000, freq_word);
		chk("noise", 4'h8, vco_noise_opt_sel);
		rd_reg(`VFC_OFS_CFG, q);
		chk("cfg", 32'h0008_0110, q);
		$display("test_midreset done");
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// whole run needs well under 8000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		print_verdict();
	end

	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		test_reset();
		test_reserved();
		test_timebase();
		test_mixed();
		test_restart();
		test_midreset();
		print_verdict();
	end
endmodule // vco_freq_calibration_config_bench
